// ===== plc_pkg.sv
// Shared constants and state types for the PHY LED, reset and pin control.
package plc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ        = 10_000_000;
  localparam int RST_MIN_NS    = 1_000;
  localparam int RST_MIN_CYC   = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999)
                                 / 1_000;
  localparam int BLINK_MS      = 50;
  localparam int BLINK_CYC     = (CLK_HZ / 1_000) * BLINK_MS;
  localparam int BLINK_W       = 20;
  localparam int RCNT_W        = 4;
  localparam int NPORT         = 2;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int CTRL_MODE3    = 0;
  localparam int CTRL_DUPLEX   = 1;
  localparam int CTRL_IRQ_EN   = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int STAT_CLKDIS   = 16;
  localparam int STAT_RMII     = 17;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------------
  // Synchronised pin vector layout
  // ----------------------------------------------------------------------
  localparam int PIN_RST_N   = 0;
  localparam int PIN_TRST_N  = 1;
  localparam int PIN_CLKDIS  = 2;
  localparam int PIN_PD      = 3;
  localparam int PIN_MODE    = 5;
  localparam int PIN_LED     = 7;
  localparam int NPIN        = 13;
  // The reset pin stage starts low, so straps wait for settled levels.
  localparam logic [NPIN-1:0] PIN_RESET = 13'h1FFE;

  // LED index within a port.
  localparam int LED_LINK  = 2;
  localparam int LED_SPEED = 1;
  localparam int LED_THIRD = 0;

  typedef struct packed {
    logic [2:0] ctrl;
    logic       mode_strap;
    logic [2:0] led_strap;
    logic [2:0] led_out;
    logic       led_oe;
    logic       pd_oe;
    logic       powerdown;
    logic       blink;
    logic       act_seen;
  } plc_port_s;

  typedef struct packed {
    plc_port_s [NPORT-1:0] port;
    logic [NPIN-1:0]    sync1;
    logic [NPIN-1:0]    sync2;
    logic [NPIN-1:0]    sync3;
    logic [NPIN-1:0]    filt;
    logic [RCNT_W-1:0]  rst_cnt;
    logic               hw_rst;
    logic               strap_pend;
    logic               clkdis;
    logic               tap_rst;
    logic               refclk_en;
    logic               refclk_50;
    logic [BLINK_W-1:0] blink_cnt;
    logic               awready;
    logic               wready;
    logic [3:0]         awaddr;
    logic [31:0]        wdata;
    logic               wstrb0;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } plc_state_s;

endpackage : plc_pkg

// ===== plc_led_reset_ctrl.sv
// LED drivers, reset handling, shared pin and reference clock control.
//
// Design decisions made here: register access over AXI4-Lite and the address map.

// What this block does
// RULE_01 - Mode 1: link LED shows link good
// RULE_02 - Modes 2/3: link LED on, blinks on activity
// RULE_03 - Speed LED on at 100, off at 10
// RULE_04 - Mode 1: third LED shows tx or rx
// RULE_05 - Mode 2: third LED shows collision
// RULE_06 - Mode 3: register selects duplex on third LED
// RULE_07 - Strap picks modes 1/2; register picks mode 3
// RULE_08 - LED active level opposes sampled strap level
// RULE_09 - Reset pin low 1 us starts reset
// RULE_10 - Hardware reset restores registers, resamples straps
// RULE_11 - Shared pin defaults to power-down input
// RULE_12 - Interrupt mode: open drain low while pending
// RULE_13 - Host enables interrupt role by register write
// RULE_14 - Reference clock 25 MHz MII, 50 RMII
// RULE_15 - Disable strap turns reference clock off
// RULE_16 - Test reset low resets test port
// RULE_17 - Blink at visible rate, stretching short bursts
module plc_led_reset_ctrl #(
  parameter int BLINK_CYCLES = plc_pkg::BLINK_CYC
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite register port.
  input  wire logic [3:0]              s_axil_awaddr,
  input  wire logic                    s_axil_awvalid,
  output logic                         s_axil_awready,
  input  wire logic [31:0]             s_axil_wdata,
  input  wire logic [3:0]              s_axil_wstrb,
  input  wire logic                    s_axil_wvalid,
  output logic                         s_axil_wready,
  output logic [1:0]                   s_axil_bresp,
  output logic                         s_axil_bvalid,
  input  wire logic                    s_axil_bready,
  input  wire logic [3:0]              s_axil_araddr,
  input  wire logic                    s_axil_arvalid,
  output logic                         s_axil_arready,
  output logic [31:0]                  s_axil_rdata,
  output logic [1:0]                   s_axil_rresp,
  output logic                         s_axil_rvalid,
  input  wire logic                    s_axil_rready,
  // Pins.
  input  wire logic                    hw_reset_n_pin,
  input  wire logic                    test_reset_n_pin,
  input  wire logic                    refclk_disable_strap,
  input  wire logic [1:0]              led_mode_strap,
  input  wire logic [1:0]              powerdown_or_irq_pin_in,
  output logic [1:0]                   powerdown_or_irq_pin_out,
  output logic [1:0]                   powerdown_or_irq_pin_oe,
  input  wire logic [1:0]              link_indicator_in,
  input  wire logic [1:0]              speed_indicator_in,
  input  wire logic [1:0]              activity_collision_indicator_in,
  output logic                         link_indicator_port_a,
  output logic                         link_indicator_port_b,
  output logic                         speed_indicator_port_a,
  output logic                         speed_indicator_port_b,
  output logic                         activity_collision_indicator_a,
  output logic                         activity_collision_indicator_b,
  output logic [1:0]                   led_oe,
  // Port status from the PHY core, same clock.
  input  wire logic [1:0]              link_good,
  input  wire logic [1:0]              speed_100,
  input  wire logic [1:0]              tx_active,
  input  wire logic [1:0]              rx_active,
  input  wire logic [1:0]              collision,
  input  wire logic [1:0]              full_duplex,
  input  wire logic [1:0]              irq_pending,
  input  wire logic                    rmii_mode,
  // Derived controls.
  output logic [1:0]                   powerdown,
  output logic                         tap_reset,
  output logic                         mac_reference_clock_out_en,
  output logic                         mac_reference_clock_out_50
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  plc_pkg::plc_state_s st_ff;
  plc_pkg::plc_state_s nxt_st;

  logic [plc_pkg::NPIN-1:0] pins;
  logic                     pin_rst_low;
  logic                     led_mode3;
  logic                     led_mode1;
  logic                     act_now;
  logic [2:0]               led_act;
  logic                     blink_tick;
  logic                     aw_take;
  logic                     w_take;
  logic [1:0]               wr_port;
  logic                     wr_hit;

  assign pins = {link_indicator_in[1], speed_indicator_in[1],
                 activity_collision_indicator_in[1],
                 link_indicator_in[0], speed_indicator_in[0],
                 activity_collision_indicator_in[0],
                 led_mode_strap, powerdown_or_irq_pin_in,
                 refclk_disable_strap, test_reset_n_pin, hw_reset_n_pin};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    led_mode3 = 1'b0;
    led_mode1 = 1'b0;
    act_now = 1'b0;
    led_act = 3'h0;
    wr_port = 2'h0;
    wr_hit = 1'b0;

    // Three-stage capture; a level counts once stages two and three agree.
    nxt_st.sync1 = pins;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    for (int b = 0; b < plc_pkg::NPIN; b++) begin
      if (st_ff.sync2[b] == st_ff.sync3[b]) begin
        nxt_st.filt[b] = st_ff.sync3[b];
      end
    end

    // The reset pin must stay low for the full minimum before acting.
    pin_rst_low = !st_ff.filt[plc_pkg::PIN_RST_N];
    if (!pin_rst_low) begin
      nxt_st.rst_cnt = '0;
      nxt_st.hw_rst = 1'b0;
    end else if (st_ff.rst_cnt >= plc_pkg::RCNT_W'(plc_pkg::RST_MIN_CYC - 1))
    begin
      nxt_st.hw_rst = 1'b1; // RULE_09
    end else begin
      nxt_st.rst_cnt = st_ff.rst_cnt + 1'b1;
    end

    nxt_st.tap_rst = !st_ff.filt[plc_pkg::PIN_TRST_N]; // RULE_16

    // Blink time base, one-cycle tick.
    blink_tick = (st_ff.blink_cnt ==
                  plc_pkg::BLINK_W'(BLINK_CYCLES - 1));
    nxt_st.blink_cnt = blink_tick ? '0 : st_ff.blink_cnt + 1'b1;

    // AXI4-Lite write: address and data are taken in either order.
    aw_take = s_axil_awvalid && st_ff.awready;
    w_take = s_axil_wvalid && st_ff.wready;
    if (aw_take) begin
      nxt_st.awready = 1'b0;
      nxt_st.awaddr = s_axil_awaddr;
    end
    if (w_take) begin
      nxt_st.wready = 1'b0;
      nxt_st.wdata = s_axil_wdata;
      nxt_st.wstrb0 = s_axil_wstrb[0];
    end
    if (!st_ff.awready && !st_ff.wready && !st_ff.bvalid) begin
      nxt_st.bvalid = 1'b1;
      unique case (st_ff.awaddr)
        plc_pkg::ADDR_CTRL_A: begin
          wr_hit = 1'b1;
          wr_port = 2'h1;
          nxt_st.bresp = plc_pkg::RESP_OKAY;
        end
        plc_pkg::ADDR_CTRL_B: begin
          wr_hit = 1'b1;
          wr_port = 2'h2;
          nxt_st.bresp = plc_pkg::RESP_OKAY;
        end
        plc_pkg::ADDR_STATUS: nxt_st.bresp = plc_pkg::RESP_SLVERR;
        default:              nxt_st.bresp = plc_pkg::RESP_DECERR;
      endcase
    end
    if (st_ff.bvalid && s_axil_bready) begin
      nxt_st.bvalid = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready = 1'b1;
    end

    // AXI4-Lite read.
    if (s_axil_arvalid && st_ff.arready) begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = '0;
      nxt_st.rresp = plc_pkg::RESP_OKAY;
      unique case (s_axil_araddr)
        plc_pkg::ADDR_CTRL_A: nxt_st.rdata[2:0] = st_ff.port[0].ctrl;
        plc_pkg::ADDR_CTRL_B: nxt_st.rdata[2:0] = st_ff.port[1].ctrl;
        plc_pkg::ADDR_STATUS: begin
          for (int p = 0; p < plc_pkg::NPORT; p++) begin
            nxt_st.rdata[p*8]   = st_ff.port[p].mode_strap;
            nxt_st.rdata[p*8+1] = st_ff.port[p].powerdown;
            nxt_st.rdata[p*8+2] = st_ff.port[p].pd_oe;
            nxt_st.rdata[p*8+3] = st_ff.port[p].blink;
            nxt_st.rdata[p*8+6 -: 3] = st_ff.port[p].led_strap;
          end
          nxt_st.rdata[plc_pkg::STAT_CLKDIS] = st_ff.clkdis;
          nxt_st.rdata[plc_pkg::STAT_RMII] = st_ff.refclk_50;
        end
        default: nxt_st.rresp = plc_pkg::RESP_DECERR;
      endcase
    end
    if (st_ff.rvalid && s_axil_rready) begin
      nxt_st.rvalid = 1'b0;
      nxt_st.arready = 1'b1;
    end

    // Straps are caught once the reset pin is high again.
    if (st_ff.strap_pend && !pin_rst_low) begin
      nxt_st.strap_pend = 1'b0; // RULE_10
      nxt_st.clkdis = st_ff.filt[plc_pkg::PIN_CLKDIS];
    end
    nxt_st.refclk_en = !st_ff.clkdis && !st_ff.strap_pend; // RULE_15
    nxt_st.refclk_50 = rmii_mode; // RULE_14

    for (int p = 0; p < plc_pkg::NPORT; p++) begin
      if (wr_hit && wr_port[p] && st_ff.wstrb0) begin
        nxt_st.port[p].ctrl = st_ff.wdata[2:0]; // RULE_13
      end
      if (st_ff.strap_pend && !pin_rst_low) begin
        nxt_st.port[p].mode_strap = st_ff.filt[plc_pkg::PIN_MODE + p];
        nxt_st.port[p].led_strap =
          st_ff.filt[plc_pkg::PIN_LED + p*3 +: 3]; // RULE_08
      end

      // Activity is stretched to at least one whole blink period.
      act_now = tx_active[p] || rx_active[p];
      if (blink_tick) begin
        nxt_st.port[p].blink = st_ff.port[p].act_seen &&
                               !st_ff.port[p].blink; // RULE_17
        nxt_st.port[p].act_seen = act_now;
      end else if (act_now) begin
        nxt_st.port[p].act_seen = 1'b1; // RULE_17
      end

      led_mode3 = st_ff.port[p].ctrl[plc_pkg::CTRL_MODE3];
      led_mode1 = !led_mode3 && st_ff.port[p].mode_strap; // RULE_07
      led_act[plc_pkg::LED_SPEED] = speed_100[p]; // RULE_03
      if (led_mode1) begin
        led_act[plc_pkg::LED_LINK] = link_good[p]; // RULE_01
        led_act[plc_pkg::LED_THIRD] = act_now; // RULE_04
      end else begin
        led_act[plc_pkg::LED_LINK] = link_good[p] &&
                                     !st_ff.port[p].blink; // RULE_02
        if (led_mode3 && st_ff.port[p].ctrl[plc_pkg::CTRL_DUPLEX]) begin
          led_act[plc_pkg::LED_THIRD] = full_duplex[p]; // RULE_06
        end else begin
          led_act[plc_pkg::LED_THIRD] = collision[p]; // RULE_05
        end
      end
      nxt_st.port[p].led_out = led_act ^ st_ff.port[p].led_strap; // RULE_08
      nxt_st.port[p].led_oe = !st_ff.strap_pend;

      // Shared pin: power-down input unless the interrupt role is set.
      if (st_ff.port[p].ctrl[plc_pkg::CTRL_IRQ_EN]) begin
        nxt_st.port[p].pd_oe = irq_pending[p]; // RULE_12
        nxt_st.port[p].powerdown = 1'b0;
      end else begin
        nxt_st.port[p].pd_oe = 1'b0;
        nxt_st.port[p].powerdown =
          !st_ff.filt[plc_pkg::PIN_PD + p]; // RULE_11
      end
    end

    // A qualified pin reset re-initialises registers and straps.
    if (st_ff.hw_rst) begin
      for (int p = 0; p < plc_pkg::NPORT; p++) begin
        nxt_st.port[p].ctrl = plc_pkg::CTRL_RESET; // RULE_10
        nxt_st.port[p].led_oe = 1'b0;
        nxt_st.port[p].pd_oe = 1'b0;
        nxt_st.port[p].blink = 1'b0;
        nxt_st.port[p].act_seen = 1'b0;
      end
      nxt_st.strap_pend = 1'b1; // RULE_10
      nxt_st.refclk_en = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.sync1 <= plc_pkg::PIN_RESET;
      st_ff.sync2 <= plc_pkg::PIN_RESET;
      st_ff.sync3 <= plc_pkg::PIN_RESET;
      st_ff.filt <= plc_pkg::PIN_RESET;
      st_ff.strap_pend <= 1'b1;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axil_awready = st_ff.awready;
  assign s_axil_wready = st_ff.wready;
  assign s_axil_bvalid = st_ff.bvalid;
  assign s_axil_bresp = st_ff.bresp;
  assign s_axil_arready = st_ff.arready;
  assign s_axil_rvalid = st_ff.rvalid;
  assign s_axil_rdata = st_ff.rdata;
  assign s_axil_rresp = st_ff.rresp;

  // The open-drain pin only ever drives low.
  assign powerdown_or_irq_pin_out = 2'h0;
  assign powerdown_or_irq_pin_oe = {st_ff.port[1].pd_oe,
                                    st_ff.port[0].pd_oe};
  assign powerdown = {st_ff.port[1].powerdown, st_ff.port[0].powerdown};
  assign led_oe = {st_ff.port[1].led_oe, st_ff.port[0].led_oe};
  assign link_indicator_port_a = st_ff.port[0].led_out[plc_pkg::LED_LINK];
  assign link_indicator_port_b = st_ff.port[1].led_out[plc_pkg::LED_LINK];
  assign speed_indicator_port_a = st_ff.port[0].led_out[plc_pkg::LED_SPEED];
  assign speed_indicator_port_b = st_ff.port[1].led_out[plc_pkg::LED_SPEED];
  assign activity_collision_indicator_a =
    st_ff.port[0].led_out[plc_pkg::LED_THIRD];
  assign activity_collision_indicator_b =
    st_ff.port[1].led_out[plc_pkg::LED_THIRD];
  assign tap_reset = st_ff.tap_rst;
  assign mac_reference_clock_out_en = st_ff.refclk_en;
  assign mac_reference_clock_out_50 = st_ff.refclk_50;

endmodule // plc_led_reset_ctrl

// ===== plc_monitor.sv
// Concurrent checks on the pins of the LED, reset and pin control block.
module plc_monitor (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       hw_reset_n_pin,
  input wire logic       test_reset_n_pin,
  input wire logic       tap_reset,
  input wire logic       rmii_mode,
  input wire logic       mac_reference_clock_out_en,
  input wire logic       mac_reference_clock_out_50,
  input wire logic       link_indicator_port_a,
  input wire logic       speed_indicator_port_a,
  input wire logic [1:0] link_indicator_in,
  input wire logic [1:0] speed_indicator_in,
  input wire logic [1:0] led_oe,
  input wire logic [1:0] link_good,
  input wire logic [1:0] speed_100,
  input wire logic [1:0] irq_pending,
  input wire logic [1:0] powerdown,
  input wire logic [1:0] powerdown_or_irq_pin_in,
  input wire logic [1:0] powerdown_or_irq_pin_out,
  input wire logic [1:0] powerdown_or_irq_pin_oe
);
  // Released LED pins show their pull, so the strap is caught here.
  logic [1:0] st_ff;
  logic [4:0] lo_ff;

  always_ff @(posedge aclk) begin
    if (!led_oe[0]) begin
      st_ff <= {link_indicator_in[0], speed_indicator_in[0]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hw_reset_n_pin) begin
      lo_ff <= 5'h00;
    end else if (lo_ff != 5'h1F) begin
      lo_ff <= lo_ff + 5'h01;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_LINK_OFF: assert property (led_oe[0] && $past(led_oe[0]) &&
    !$past(link_good[0]) |-> link_indicator_port_a == st_ff[1])
    else $error("link LED lit without link");
  AST_SPEED: assert property (led_oe[0] && $past(led_oe[0]) |->
    speed_indicator_port_a == ($past(speed_100[0]) ^ st_ff[0]))
    else $error("speed LED level wrong");
  AST_IRQ_OE: assert property (powerdown_or_irq_pin_oe[0] |->
    $past(irq_pending[0])) else $error("shared pin pulled without irq");
  AST_PIN_OUT: assert property (powerdown_or_irq_pin_out == 2'h0)
    else $error("shared pin driven high");
  AST_PD_IN: assert property ($rose(powerdown[0]) |->
    !$past(powerdown_or_irq_pin_in[0], 4)) else $error("power-down w/o pin");
  AST_TAP_ON: assert property (!test_reset_n_pin [*8] |-> tap_reset)
    else $error("test reset not applied");
  AST_TAP_OFF: assert property (test_reset_n_pin [*8] |-> !tap_reset)
    else $error("test reset stuck");
  AST_REFSEL: assert property (mac_reference_clock_out_en &&
    $stable(rmii_mode) |-> mac_reference_clock_out_50 == rmii_mode)
    else $error("reference clock rate wrong");
  AST_HWRST: assert property (lo_ff == 5'h14 |-> led_oe == 2'h0 &&
    !mac_reference_clock_out_en) else $error("long reset pulse ignored");
  AST_HWRST_SHORT: assert property ($rose(hw_reset_n_pin) &&
    lo_ff <= 5'h05 && led_oe[0] |=> led_oe[0] [*8])
    else $error("short reset pulse acted on");

  COV_IRQ: cover property (powerdown_or_irq_pin_oe[0]);
  COV_PD: cover property (powerdown[0]);
  COV_RST: cover property (lo_ff == 5'h14);
endmodule // plc_monitor

bind plc_led_reset_ctrl plc_monitor u_mon (
  .aclk, .aresetn, .hw_reset_n_pin, .test_reset_n_pin, .tap_reset,
  .rmii_mode, .mac_reference_clock_out_en, .mac_reference_clock_out_50,
  .link_indicator_port_a, .speed_indicator_port_a, .link_indicator_in,
  .speed_indicator_in, .led_oe, .link_good, .speed_100, .irq_pending,
  .powerdown, .powerdown_or_irq_pin_in, .powerdown_or_irq_pin_out,
  .powerdown_or_irq_pin_oe
);

// ===== plc_board_model.sv
// Board model: LED strap pulls, shared pin pull-up and power-down drive.
module plc_board_model (
  input  wire logic [2:0] pull_a,
  input  wire logic [2:0] pull_b,
  input  wire logic [1:0] led_oe,
  input  wire logic [1:0] pd_oe,
  input  wire logic [1:0] pd_out,
  input  wire logic [1:0] pd_hold_n,
  input  wire logic [1:0] link,
  input  wire logic [1:0] spd,
  input  wire logic [1:0] act,
  output logic      [1:0] link_in,
  output logic      [1:0] spd_in,
  output logic      [1:0] act_in,
  output logic      [1:0] pd_in
);
  // A released LED pin rests at its pull, which is the strap it reads.
  assign link_in = (led_oe & link) | (~led_oe & {pull_b[2], pull_a[2]});
  assign spd_in = (led_oe & spd) | (~led_oe & {pull_b[1], pull_a[1]});
  assign act_in = (led_oe & act) | (~led_oe & {pull_b[0], pull_a[0]});
  // Pulled up; the board or the open-drain driver may pull it low.
  assign pd_in = ~((pd_oe & ~pd_out) | ~pd_hold_n);
endmodule // plc_board_model

// ===== plc_led_reset_ctrl_tb.sv
// Self-checking bench for the LED, reset and pin control block.
module plc_led_reset_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0, aresetn = 1'h0, s_axil_awready, s_axil_wready;
  logic s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0;
  logic s_axil_arvalid = 1'h0, s_axil_rready = 1'h0, s_axil_arready;
  logic [3:0] s_axil_awaddr = 4'h0, s_axil_araddr = 4'h0, s_axil_wstrb = 4'hF;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
  logic [1:0] s_axil_bresp, s_axil_rresp, led_oe, powerdown;
  logic s_axil_bvalid, s_axil_rvalid, tap_reset, ref_en, ref_50;
  logic hw_reset_n_pin = 1'h1, test_reset_n_pin = 1'h1, rmii_mode = 1'h1;
  logic refclk_disable_strap = 1'h0;
  logic [1:0] led_mode_strap = 2'h1, link_good = 2'h0, speed_100 = 2'h0;
  logic [1:0] tx_active = 2'h0, rx_active = 2'h0, collision = 2'h0;
  logic [1:0] full_duplex = 2'h0, irq_pending = 2'h0, pd_hold_n = 2'h3;
  logic [1:0] pin_in, pin_out, pin_oe, link_in, spd_in, act_in;
  logic [1:0] link, spd, act;
  logic [2:0] pull_a = 3'h2, pull_b = 3'h5;
  int n_errors = 0;
  int n_checks = 0;

  always #50 aclk = ~aclk;

  plc_led_reset_ctrl #(.BLINK_CYCLES(8)) DUT (
    .aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
    .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
    .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
    .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
    .s_axil_rvalid, .s_axil_rready, .hw_reset_n_pin, .test_reset_n_pin,
    .refclk_disable_strap, .led_mode_strap, .powerdown_or_irq_pin_in(pin_in),
    .powerdown_or_irq_pin_out(pin_out), .powerdown_or_irq_pin_oe(pin_oe),
    .link_indicator_in(link_in), .speed_indicator_in(spd_in),
    .activity_collision_indicator_in(act_in), .led_oe,
    .link_indicator_port_a(link[0]), .link_indicator_port_b(link[1]),
    .speed_indicator_port_a(spd[0]), .speed_indicator_port_b(spd[1]),
    .activity_collision_indicator_a(act[0]),
    .activity_collision_indicator_b(act[1]), .link_good, .speed_100,
    .tx_active, .rx_active, .collision, .full_duplex, .irq_pending,
    .rmii_mode, .powerdown, .tap_reset, .mac_reference_clock_out_en(ref_en),
    .mac_reference_clock_out_50(ref_50)
  );

  plc_board_model u_board (
    .pull_a, .pull_b, .led_oe, .pd_oe(pin_oe), .pd_out(pin_out), .pd_hold_n,
    .link, .spd, .act, .link_in, .spd_in, .act_in, .pd_in(pin_in)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bit pa;
    bit pw;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'h1;
    s_axil_wvalid <= 1'h1;
    s_axil_bready <= 1'h1;
    pa = 1'h1;
    pw = 1'h1;
    do begin
      @(posedge aclk);
      if (pa && s_axil_awready === 1'h1) begin
        s_axil_awvalid <= 1'h0;
        pa = 1'h0;
      end
      if (pw && s_axil_wready === 1'h1) begin
        s_axil_wvalid <= 1'h0;
        pw = 1'h0;
      end
    end while (pa || pw);
    while (s_axil_bvalid !== 1'h1) @(posedge aclk);
    s_axil_bready <= 1'h0;
    cmp("bresp", 32'(r), 32'(s_axil_bresp));
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'h1;
    s_axil_rready <= 1'h1;
    do @(posedge aclk); while (s_axil_arready !== 1'h1);
    s_axil_arvalid <= 1'h0;
    while (s_axil_rvalid !== 1'h1) @(posedge aclk);
    s_axil_rready <= 1'h0;
    cmp("rdata", e, s_axil_rdata);
    cmp("rresp", 32'(r), 32'(s_axil_rresp));
  endtask

  task automatic t_mode1;
    for (int i = 0; i < 16; i++) begin
      link_good[0] <= i[0];
      speed_100[0] <= i[1];
      tx_active[0] <= i[2];
      rx_active[0] <= i[3];
      tick(2);
      cmp("link_a", 32'(i[0] ^ pull_a[2]), 32'(link[0]));
      cmp("speed_a", 32'(i[1] ^ pull_a[1]), 32'(spd[0]));
      cmp("act_a", 32'(|i[3:2] ^ pull_a[0]), 32'(act[0]));
    end
    tx_active[0] <= 1'h0;
    rx_active[0] <= 1'h0;
  endtask

  task automatic t_mode2;
    int seen;
    link_good[1] <= 1'h1;
    collision[1] <= 1'h1;
    tick(40);
    cmp("link_b", 32'(!pull_b[2]), 32'(link[1]));
    cmp("col_b", 32'(!pull_b[0]), 32'(act[1]));
    collision[1] <= 1'h0;
    tx_active[1] <= 1'h1;
    tick(1);
    tx_active[1] <= 1'h0;
    seen = 0;
    repeat (40) begin
      tick(1);
      seen += (link[1] === pull_b[2]);
    end
    cmp("blink_b", 32'h1, 32'(seen > 0 && seen < 40));
    cmp("col_b", 32'(pull_b[0]), 32'(act[1]));
    cmp("spd_b", 32'(pull_b[1]), 32'(spd[1]));
  endtask

  task automatic t_regs;
    wr(plc_pkg::ADDR_CTRL_A, 32'h1, plc_pkg::RESP_OKAY);
    collision[0] <= 1'h1;
    tick(3);
    cmp("col_a", 32'(!pull_a[0]), 32'(act[0]));
    wr(plc_pkg::ADDR_CTRL_A, 32'h3, plc_pkg::RESP_OKAY);
    tick(3);
    cmp("dup_a", 32'(pull_a[0]), 32'(act[0]));
    full_duplex[0] <= 1'h1;
    tick(3);
    cmp("dup_a", 32'(!pull_a[0]), 32'(act[0]));
    collision[0] <= 1'h0;
    full_duplex[0] <= 1'h0;
    rd(plc_pkg::ADDR_CTRL_A, 32'h3, plc_pkg::RESP_OKAY);
    rd(plc_pkg::ADDR_CTRL_B, 32'h0, plc_pkg::RESP_OKAY);
    rd(plc_pkg::ADDR_STATUS, 32'h0002_5021, plc_pkg::RESP_OKAY);
    wr(plc_pkg::ADDR_STATUS, 32'h0, plc_pkg::RESP_SLVERR);
    wr(4'hC, 32'h7, plc_pkg::RESP_DECERR);
    rd(4'hC, 32'h0, plc_pkg::RESP_DECERR);
  endtask

  task automatic t_pin;
    pd_hold_n[0] <= 1'h0;
    tick(8);
    cmp("pd_a", 32'h1, 32'(powerdown[0]));
    pd_hold_n[0] <= 1'h1;
    irq_pending[0] <= 1'h1;
    tick(8);
    cmp("pd_a", 32'h0, 32'(powerdown[0]));
    cmp("pin_a", 32'h1, 32'(pin_in[0]));
    wr(plc_pkg::ADDR_CTRL_A, 32'h4, plc_pkg::RESP_OKAY);
    tick(8);
    cmp("pin_a", 32'h0, 32'(pin_in[0]));
    cmp("pd_a", 32'h0, 32'(powerdown[0]));
    irq_pending[0] <= 1'h0;
    tick(2);
    cmp("pin_a", 32'h1, 32'(pin_in[0]));
  endtask

  task automatic t_misc;
    rmii_mode <= 1'h0;
    test_reset_n_pin <= 1'h0;
    tick(8);
    cmp("ref_50", 32'h0, 32'(ref_50));
    cmp("ref_en", 32'h1, 32'(ref_en));
    cmp("tap", 32'h1, 32'(tap_reset));
    rmii_mode <= 1'h1;
    test_reset_n_pin <= 1'h1;
    tick(8);
    cmp("ref_50", 32'h1, 32'(ref_50));
    cmp("tap", 32'h0, 32'(tap_reset));
  endtask

  task automatic t_hwrst;
    hw_reset_n_pin <= 1'h0;
    tick(5);
    hw_reset_n_pin <= 1'h1;
    tick(20);
    rd(plc_pkg::ADDR_CTRL_A, 32'h4, plc_pkg::RESP_OKAY);
    refclk_disable_strap <= 1'h1;
    led_mode_strap <= 2'h2;
    pull_a <= 3'h3;
    hw_reset_n_pin <= 1'h0;
    tick(30);
    cmp("led_oe", 32'h0, 32'(led_oe));
    hw_reset_n_pin <= 1'h1;
    collision[0] <= 1'h1;
    tick(20);
    rd(plc_pkg::ADDR_CTRL_A, 32'h0, plc_pkg::RESP_OKAY);
    cmp("ref_en", 32'h0, 32'(ref_en));
    cmp("col_a", 32'(!pull_a[0]), 32'(act[0]));
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    tick(5000);
    n_errors++;
    report_and_stop();
  end

  initial begin
    tick(2);
    aresetn <= 1'h1;
    tick(10);
    t_mode1();
    t_mode2();
    t_regs();
    t_pin();
    t_misc();
    t_hwrst();
    report_and_stop();
  end
endmodule // plc_led_reset_ctrl_tb
